// ### hdl/pm_ctrl_pkg.sv
// link power-management control constants: register indices, field positions, resets
// assumes a plain register port with one-cycle strobes and 32-bit data
package pm_ctrl_pkg;
   localparam int          ADDR_W          = 8;
   localparam int          DATA_W          = 32;
   // register byte addresses
   localparam logic [7:0]  CTRL_ADDR       = 8'h00;
   localparam logic [7:0]  DEVCAP_ADDR     = 8'h94;
   localparam logic [7:0]  AER_NEXT_ADDR   = 8'h04;
   localparam logic [7:0]  STATUS_ADDR     = 8'h08;
   // config-space offset of the error-reporting capability; not decoded on this port
   localparam logic [11:0] AER_NEXT_INDEX  = 12'h102;
   // control register fields
   localparam int          L1_LAT_HI       = 15;
   localparam int          L1_LAT_LO       = 13;
   localparam int          VC_EN_BIT       = 12;
   localparam int          CLK_STOP_BIT    = 11;
   localparam int          WAKE_SEL_BIT    = 10;
   // device capabilities mirror field
   localparam int          MIRROR_HI       = 11;
   localparam int          MIRROR_LO       = 9;
   // next-capability field position and values
   localparam int          NEXT_LO         = 20;
   localparam int          NEXT_HI         = 31;
   localparam logic [11:0] NEXT_VC_OFF     = 12'h000;
   localparam logic [11:0] NEXT_VC_ON      = 12'h150;
   // reset values
   localparam logic [2:0]  L1_LAT_RESET    = 3'h0;
   localparam logic        CLK_STOP_RESET  = 1'b0;
   localparam logic        WAKE_SEL_RESET  = 1'b0;
   localparam logic        VC_EN_FIXED     = 1'b0;
   // latency codes with their lower bound in microseconds
   localparam logic [2:0]  L1_CODE_1US     = 3'h1;
   localparam logic [2:0]  L1_CODE_32US    = 3'h6;
   // status bits
   localparam int          STAT_D3_BIT     = 0;
   localparam int          STAT_L2_BIT     = 1;
   localparam int          STAT_CLKRUN_BIT = 2;
   localparam int          STAT_BEACON_BIT = 3;
   localparam int          STAT_WAKE_BIT   = 4;
endpackage

// ### hdl/sync_2ff.sv
// two-flop synchroniser for a group of level inputs
// assumes inputs are quasi-static levels from another domain
`timescale 1ns/1ps
module sync_2ff #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rstn,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   logic [W-1:0] stage1_reg;
   logic [W-1:0] stage1_next;
   logic [W-1:0] dout_next;

   always_comb begin
      stage1_next = din;
      dout_next   = stage1_reg;
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         stage1_reg <= '0;
         dout       <= '0;
      end else begin
         stage1_reg <= stage1_next;
         dout       <= dout_next;
      end
   end
endmodule

// ### hdl/pcie_power_mgmt_control.sv
// link power-management control fields, their mirrors, and clock/wake steering
// assumes core clock 20 MHz; d3 and l2 state levels arrive from another domain
//
// Summary of operation
// - l1 exit-latency code: doubling ranges, 001 is 1-2 us, 110 is 32-64 us
// - latency field at bits 15:13, resets 000, mirrored to device cap 11:9
// - vc capability enable reads zero, so next-capability offset reads 000h
// - if vc enable were one, next-capability offset would read 150h
// - clock-stop enable zero keeps secondary clocks running in d3
// - clock-stop enable one stops secondary clocks on entering d3
// - wake select zero: wake signal only in l2, no beacon
`timescale 1ns/1ps
module pcie_power_mgmt_control
   import pm_ctrl_pkg::*;
(
   input  wire logic                              clk,
   input  wire logic                              rstn,
   input  wire logic [pm_ctrl_pkg::ADDR_W-1:0]    regAddr,
   input  wire logic [pm_ctrl_pkg::DATA_W-1:0]    regWdata,
   input  wire logic                              regWr,
   input  wire logic                              regRd,
   input  wire logic                              inD3,
   input  wire logic                              inL2,
   input  wire logic                              wakeRequest,
   output logic      [pm_ctrl_pkg::DATA_W-1:0]    regRdata,
   output logic                                   secondaryClockRun,
   output logic                                   beaconOut,
   output logic                                   wakeOut,
   output logic      [2:0]                        endpoint_l1_exit_latency_limit_mirror,
   output logic      [11:0]                       aerNextOffset
);
   import pm_ctrl_pkg::*;

   logic        rstMeta_reg;
   logic        rstSync_reg;
   logic        rstnInt;
   logic [2:0]  pinSync;
   logic        d3Sync;
   logic        l2Sync;
   logic        wakeReqSync;

   logic [2:0]  l1_exit_latency_limit_reg;
   logic [2:0]  l1_exit_latency_limit_next;
   logic        secondary_clock_stop_enable_reg;
   logic        secondary_clock_stop_enable_next;
   logic        wakeSel_reg;
   logic        wakeSel_next;
   logic        virtual_channel_cap_enable;
   logic [DATA_W-1:0] regRdata_next;
   logic        secondaryClockRun_next;
   logic        beaconOut_next;
   logic        wakeOut_next;
   logic [2:0]  mirror_next;
   logic [11:0] aerNext_next;

   // reset is asserted asynchronously, released through two flops
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rstMeta_reg <= 1'b0;
         rstSync_reg <= 1'b0;
      end else begin
         rstMeta_reg <= 1'b1;
         rstSync_reg <= rstMeta_reg;
      end
   end
   assign rstnInt = rstSync_reg;

   sync_2ff #(.W(3)) u_pin_sync (
      .clk  (clk),
      .rstn (rstnInt),
      .din  ({wakeRequest, inL2, inD3}),
      .dout (pinSync)
   );
   assign d3Sync      = pinSync[0];
   assign l2Sync      = pinSync[1];
   assign wakeReqSync = pinSync[2];

   // read-only bit held as a constant so the offset select stays in logic
   assign virtual_channel_cap_enable = VC_EN_FIXED;

   function automatic logic [11:0] nextCapOffset(input logic vcEn);
      nextCapOffset = vcEn ? NEXT_VC_ON : NEXT_VC_OFF;
   endfunction

   function automatic logic [DATA_W-1:0] ctrlWord(input logic [2:0] lat, input logic vcEn,
                                                  input logic stopEn, input logic wSel);
      logic [DATA_W-1:0] w;
      w = '0;
      w[L1_LAT_HI:L1_LAT_LO] = lat;
      w[VC_EN_BIT]           = vcEn;
      w[CLK_STOP_BIT]        = stopEn;
      w[WAKE_SEL_BIT]        = wSel;
      ctrlWord = w;
   endfunction

   // register writes; latency code stored as written, meaning per its doubling table
   always_comb begin
      l1_exit_latency_limit_next       = l1_exit_latency_limit_reg;
      secondary_clock_stop_enable_next = secondary_clock_stop_enable_reg;
      wakeSel_next                     = wakeSel_reg;
      if (regWr && regAddr == CTRL_ADDR) begin
         l1_exit_latency_limit_next       = regWdata[L1_LAT_HI:L1_LAT_LO];
         secondary_clock_stop_enable_next = regWdata[CLK_STOP_BIT];
         wakeSel_next                     = regWdata[WAKE_SEL_BIT];
      end
   end

   // read path plus steering outputs, all registered
   always_comb begin
      regRdata_next = '0;
      if (regRd) begin
         unique case (regAddr)
            CTRL_ADDR: begin
               regRdata_next = ctrlWord(l1_exit_latency_limit_reg, virtual_channel_cap_enable,
                                        secondary_clock_stop_enable_reg, wakeSel_reg);
            end
            DEVCAP_ADDR: begin
               regRdata_next[MIRROR_HI:MIRROR_LO] = l1_exit_latency_limit_reg;
            end
            AER_NEXT_ADDR: begin
               regRdata_next[NEXT_HI:NEXT_LO] = nextCapOffset(virtual_channel_cap_enable);
            end
            STATUS_ADDR: begin
               regRdata_next[STAT_D3_BIT]     = d3Sync;
               regRdata_next[STAT_L2_BIT]     = l2Sync;
               regRdata_next[STAT_CLKRUN_BIT] = secondaryClockRun;
               regRdata_next[STAT_BEACON_BIT] = beaconOut;
               regRdata_next[STAT_WAKE_BIT]   = wakeOut;
            end
            default: begin
               regRdata_next = '0;
            end
         endcase
      end
      // clocks run outside d3, and in d3 unless stop is enabled
      secondaryClockRun_next = !(d3Sync && secondary_clock_stop_enable_reg);
      // wake in l2: beacon only when selected, wake signal otherwise
      beaconOut_next = l2Sync && wakeReqSync && wakeSel_reg;
      wakeOut_next   = l2Sync && wakeReqSync && !wakeSel_reg;
      mirror_next    = l1_exit_latency_limit_reg;
      aerNext_next   = nextCapOffset(virtual_channel_cap_enable);
   end

   always_ff @(posedge clk or negedge rstnInt) begin
      if (!rstnInt) begin
         l1_exit_latency_limit_reg       <= L1_LAT_RESET;
         secondary_clock_stop_enable_reg <= CLK_STOP_RESET;
         wakeSel_reg                     <= WAKE_SEL_RESET;
         regRdata                        <= '0;
         secondaryClockRun               <= 1'b1;
         beaconOut                       <= 1'b0;
         wakeOut                         <= 1'b0;
         endpoint_l1_exit_latency_limit_mirror      <= L1_LAT_RESET;
         aerNextOffset                   <= NEXT_VC_OFF;
      end else begin
         l1_exit_latency_limit_reg       <= l1_exit_latency_limit_next;
         secondary_clock_stop_enable_reg <= secondary_clock_stop_enable_next;
         wakeSel_reg                     <= wakeSel_next;
         regRdata                        <= regRdata_next;
         secondaryClockRun               <= secondaryClockRun_next;
         beaconOut                       <= beaconOut_next;
         wakeOut                         <= wakeOut_next;
         endpoint_l1_exit_latency_limit_mirror      <= mirror_next;
         aerNextOffset                   <= aerNext_next;
      end
   end

   // checks
   property p_mirror;
      @(posedge clk) disable iff (!rstnInt)
      endpoint_l1_exit_latency_limit_mirror == $past(l1_exit_latency_limit_reg);
   endproperty
   a_mirror: assert property (p_mirror) else $error("latency mirror mismatch");

   property p_write_lat;
      @(posedge clk) disable iff (!rstnInt)
      (regWr && regAddr == CTRL_ADDR) |=> ##1
         endpoint_l1_exit_latency_limit_mirror == $past(regWdata[L1_LAT_HI:L1_LAT_LO], 2);
   endproperty
   a_write_lat: assert property (p_write_lat) else $error("latency write lost");

   property p_aer_off;
      @(posedge clk) disable iff (!rstnInt)
      aerNextOffset == NEXT_VC_OFF;
   endproperty
   a_aer_off: assert property (p_aer_off) else $error("next offset not 000h");

   property p_vc_read;
      @(posedge clk) disable iff (!rstnInt)
      (regRd && regAddr == CTRL_ADDR) |=> !regRdata[VC_EN_BIT];
   endproperty
   a_vc_read: assert property (p_vc_read) else $error("vc enable read nonzero");

   // the offset seen by software, not just the port copy
   property p_next_read;
      @(posedge clk) disable iff (!rstnInt)
      (regRd && regAddr == AER_NEXT_ADDR) |=> regRdata[NEXT_HI:NEXT_LO] == NEXT_VC_OFF;
   endproperty
   a_next_read: assert property (p_next_read) else $error("next read wrong");

   property p_clk_keep;
      @(posedge clk) disable iff (!rstnInt)
      (!secondary_clock_stop_enable_reg) |=> secondaryClockRun;
   endproperty
   a_clk_keep: assert property (p_clk_keep) else $error("clocks stopped, stop off");

   sequence s_d3_stop;
      d3Sync && secondary_clock_stop_enable_reg;
   endsequence
   property p_clk_stop;
      @(posedge clk) disable iff (!rstnInt)
      s_d3_stop |=> !secondaryClockRun;
   endproperty
   a_clk_stop: assert property (p_clk_stop) else $error("clocks not stopped in d3");

   property p_no_beacon;
      @(posedge clk) disable iff (!rstnInt)
      (!wakeSel_reg) |=> !beaconOut;
   endproperty
   a_no_beacon: assert property (p_no_beacon) else $error("beacon with wake select 0");

   property p_beacon;
      @(posedge clk) disable iff (!rstnInt)
      (wakeSel_reg && l2Sync && wakeReqSync) |=> beaconOut && !wakeOut;
   endproperty
   a_beacon: assert property (p_beacon) else $error("beacon not generated");

   property p_wake;
      @(posedge clk) disable iff (!rstnInt)
      (!wakeSel_reg && l2Sync && wakeReqSync) |=> wakeOut && !beaconOut;
   endproperty
   a_wake: assert property (p_wake) else $error("wake signal not driven");
endmodule

// ### testbench/pcie_host_model.sv
// host-side power-state source for the power-management control block
// assumes the bench asks for state changes; levels move one edge later
`timescale 1ns/1ps
module pcie_host_model (
   input  wire logic clk,
   input  wire logic wantD3,
   input  wire logic wantL2,
   input  wire logic wantWake,
   input  wire logic secondaryClockRun,
   output logic      inD3,
   output logic      inL2,
   output logic      wakeRequest,
   output logic      refClkOn
);
   initial begin
      inD3 = 1'b0;
      inL2 = 1'b0;
      wakeRequest = 1'b0;
   end
   always @(posedge clk) begin
      inD3 <= wantD3;
      inL2 <= wantL2;
      wakeRequest <= wantWake;
   end
   // reference may stop only in d3 once the secondary clocks are stopped
   assign refClkOn = !inD3 || secondaryClockRun;
endmodule

// ### testbench/pcie_power_mgmt_control_test.sv
// self-checking bench for the power-management control block
// assumes pm_ctrl_pkg and the host model are compiled first
`timescale 1ns/1ps
module pcie_power_mgmt_control_test;
   import pm_ctrl_pkg::*;
   logic        clk = 1'b0;
   logic        rstn = 1'b0;
   logic [7:0]  regAddr = 8'h00;
   logic [31:0] regWdata = 32'h0;
   logic        regWr = 1'b0;
   logic        regRd = 1'b0;
   logic        wantD3 = 1'b0;
   logic        wantL2 = 1'b0;
   logic        wantWake = 1'b0;
   logic        inD3, inL2, wakeRequest, secondaryClockRun, beaconOut, wakeOut;
   logic        refClkOn;
   logic [31:0] regRdata;
   logic [2:0]  mirror;
   logic [11:0] aerNext;
   int          mismatches = 0;
   int          cmpCount = 0;
   int          cycles = 0;
   always #25 clk = ~clk;
   pcie_power_mgmt_control dut (.clk(clk), .rstn(rstn), .regAddr(regAddr),
      .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .inD3(inD3), .inL2(inL2),
      .wakeRequest(wakeRequest), .regRdata(regRdata), .secondaryClockRun(secondaryClockRun),
      .beaconOut(beaconOut), .wakeOut(wakeOut), .endpoint_l1_exit_latency_limit_mirror(mirror),
      .aerNextOffset(aerNext));
   pcie_host_model host (.clk(clk), .wantD3(wantD3), .wantL2(wantL2), .wantWake(wantWake),
      .secondaryClockRun(secondaryClockRun), .inD3(inD3), .inL2(inL2),
      .wakeRequest(wakeRequest), .refClkOn(refClkOn));
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   // only bits 15:10 are kept; the vc enable always reads zero
   function automatic logic [31:0] ctrlExp(input logic [31:0] w);
      return {16'h0, w[15:13], VC_EN_FIXED, w[11:10], 10'h0};
   endfunction
   task automatic stop_test();
      if (mismatches == 0 && cmpCount > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      cmpCount++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
      @(negedge clk);
      d = regRdata;
   endtask
   // ceiling well above the roughly 155 cycles the sequence needs
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         mismatches++;
         stop_test();
      end
   end
   initial begin
      logic [31:0] d, w, seed;
      logic        s, b;
      seed = 32'h5c8e;
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      repeat (3) @(posedge clk);
      rd(CTRL_ADDR, d);
      chk("ctrl reset", d & 32'h0000FC00, 32'h0);
      chk("mirror reset", 32'(mirror), 32'(L1_LAT_RESET));
      for (int i = 0; i < 8; i++) begin
         seed = lfsr(seed);
         w = (seed & 32'hFFFF1FFF) | 32'h1000 | (32'(i) << L1_LAT_LO);
         wr(CTRL_ADDR, w);
         rd(CTRL_ADDR, d);
         chk("ctrl", d & 32'h0000FC00, ctrlExp(w));
         rd(DEVCAP_ADDR, d);
         chk("devcap", 32'(d[MIRROR_HI:MIRROR_LO]), 32'(i));
         chk("mirror port", 32'(mirror), 32'(i));
         rd(AER_NEXT_ADDR, d);
         chk("next field", 32'(d[NEXT_HI:NEXT_LO]), 32'(NEXT_VC_OFF));
         chk("next port", 32'(aerNext), 32'(NEXT_VC_OFF));
      end
      // unmapped place: write ignored, read zero
      wr(8'h40, 32'hFFFFFFFF);
      rd(CTRL_ADDR, d);
      chk("ctrl kept", d & 32'h0000FC00, ctrlExp(w));
      rd(8'h40, d);
      chk("unmapped", d, 32'h0);
      @(negedge clk);
      chk("rdata idle", regRdata, 32'h0);
      for (int k = 0; k < 4; k++) begin
         s = k[1];
         b = k[0];
         wr(CTRL_ADDR, {20'h0, s, b, 10'h0});
         @(posedge clk);
         wantD3 <= 1'b1;
         wantL2 <= 1'b1;
         wantWake <= 1'b1;
         repeat (6) @(posedge clk);
         @(negedge clk);
         chk("clk run d3", 32'(secondaryClockRun), 32'(!s));
         chk("beacon", 32'(beaconOut), 32'(b));
         chk("wake", 32'(wakeOut), 32'(!b));
         chk("ref clock", 32'(refClkOn | !secondaryClockRun), 32'h1);
         rd(STATUS_ADDR, d);
         chk("status", 32'(d[4:0]), 32'({!b, b, !s, 2'b11}));
         @(posedge clk);
         wantD3 <= 1'b0;
         wantL2 <= 1'b0;
         wantWake <= 1'b0;
         repeat (6) @(posedge clk);
         @(negedge clk);
         chk("clk run d0", 32'(secondaryClockRun), 32'h1);
         chk("beacon idle", 32'(beaconOut), 32'h0);
         chk("wake idle", 32'(wakeOut), 32'h0);
      end
      stop_test();
   end
endmodule
